// ### include/sor_pkg.sv
package sor_pkg;
  localparam int OUT_IDX_W = 8;
  localparam int OUT_IDX_MAX = 141;
  localparam int OUT_BANK_PTS = 18;
  localparam int OUT_BANK0_IDX = 40;
  localparam int OUT_BANK1_IDX = 80;
  localparam int OUT_BANK2_IDX = 120;
  localparam int OUT_BASE_4PT = 4;
  localparam int OUT_BASE_24PT = 8;
  localparam int OUT_BASE_40PT = 16;
  localparam int OUT_BASE_48PT = 18;
  localparam int OUT_PHYS_MAX = 72;
  localparam int REL_IDX_W = 11;
  localparam int REL_IDX_MAX = 1277;
  localparam int REL_IDX_MAX_SMALL = 317;
  localparam int REL_PHYS_MAX = 1024;
  localparam int AND_INPUTS = 4;

  typedef enum logic [1:0] {
    SOR_VAR_4PT = 2'h0,
    SOR_VAR_24PT = 2'h1,
    SOR_VAR_40PT = 2'h2,
    SOR_VAR_48PT = 2'h3
  } sor_variant_t;

  // Octal digits: tens hold groups of eight, units 0..7
  function automatic int sor_octal_pos(input int idx);
    sor_octal_pos = (idx / 10) * 8 + (idx % 10);
  endfunction : sor_octal_pos
endpackage : sor_pkg

// ### rtl/sor_and4.sv
`timescale 1ns/1ps
module sor_and4 #(
  parameter int N = 4
) (
  input wire logic [N-1:0] i_in,
  input wire logic [N-1:0] i_used,
  output logic o_out
);
  import sor_pkg::*;
  if (N < 1 || N > AND_INPUTS) begin : g_bad_n
    $error("sor_and4: N out of range");
  end
  // Unused inputs count as on so fewer than four may be wired
  assign o_out = &(i_in | ~i_used);
endmodule : sor_and4

// ### rtl/sor_scan.sv
`timescale 1ns/1ps
// Behaviour
// - Drive selected output terminal from element input
// - Output readback shows previous scan input
// - Output indices Q0..Q141, banks 40/80/120
// - Base range 4, 8, 16 or 18 points
// - Relay output shows previous scan input
// - Relay indices to M1277, small to M317
// - Relay indices allocated rising from zero
// - Retained relays keep value at start
// - Wired source overrides manual relay change
// - AND of up to four inputs
// - Outputs off during first scan after start
module sor_scan #(
  parameter sor_pkg::sor_variant_t VARIANT = sor_pkg::SOR_VAR_48PT,
  parameter bit SMALL = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_scan,
  input wire logic i_start,
  input wire logic i_q_we,
  input wire logic [sor_pkg::OUT_IDX_W-1:0] i_q_idx,
  input wire logic i_q_in,
  input wire logic i_m_we,
  input wire logic [sor_pkg::REL_IDX_W-1:0] i_m_idx,
  input wire logic i_m_in,
  input wire logic i_m_wired,
  input wire logic i_m_manual_we,
  input wire logic i_m_manual_val,
  input wire logic i_m_keep,
  input wire logic i_m_alloc,
  input wire logic [3:0] i_and_in,
  input wire logic [3:0] i_and_used,
  output logic [sor_pkg::OUT_PHYS_MAX-1:0] o_terminals,
  output logic o_q_readback,
  output logic o_m_out,
  output logic [sor_pkg::REL_IDX_W-1:0] o_m_next_idx,
  output logic o_idx_err,
  output logic o_and_out
);
  import sor_pkg::*;

  typedef struct packed {
    logic first;
    logic [OUT_PHYS_MAX-1:0] term;
    logic [OUT_PHYS_MAX-1:0] qprev;
    logic [OUT_PHYS_MAX-1:0] qcur;
    logic [REL_PHYS_MAX-1:0] mcur;
    logic [REL_PHYS_MAX-1:0] mprev;
    logic [REL_PHYS_MAX-1:0] keep;
    logic [REL_IDX_W-1:0] alloc;
    logic qrb;
    logic mout;
    logic err;
  } sor_state_t;

  sor_state_t st;
  sor_state_t next_st;

  function automatic int base_pts(input sor_variant_t v);
    case (v)
      SOR_VAR_4PT: base_pts = OUT_BASE_4PT;
      SOR_VAR_24PT: base_pts = OUT_BASE_24PT;
      SOR_VAR_40PT: base_pts = OUT_BASE_40PT;
      default: base_pts = OUT_BASE_48PT;
    endcase
  endfunction : base_pts

  // Map a decimal output index to a physical slot, -1 if not fitted
  function automatic int q_slot(input int idx);
    int b;
    int p;
    int k;
    b = base_pts(VARIANT);
    q_slot = -1;
    k = 0;
    if (idx <= OUT_IDX_MAX && idx % 10 < 8) begin
      p = sor_octal_pos(idx);
      if (idx < OUT_BANK0_IDX) begin
        if (p < b) q_slot = p;
      end else if (VARIANT != SOR_VAR_4PT) begin
        // Offset inside the bank is bounded before the bank base is added
        if (idx >= OUT_BANK2_IDX) begin
          k = 3;
          p = p - sor_octal_pos(OUT_BANK2_IDX);
        end else if (idx >= OUT_BANK1_IDX) begin
          k = 2;
          p = p - sor_octal_pos(OUT_BANK1_IDX);
        end else begin
          k = 1;
          p = p - sor_octal_pos(OUT_BANK0_IDX);
        end
        if (p < OUT_BANK_PTS) q_slot = k * OUT_BANK_PTS + p;
      end
    end
  endfunction : q_slot

  // Highest relay index this variant fits
  localparam int M_LIM = SMALL ? REL_IDX_MAX_SMALL : REL_IDX_MAX;

  function automatic int m_slot(input int idx);
    int lim;
    lim = M_LIM;
    m_slot = -1;
    if (idx <= lim && idx % 10 < 8) m_slot = sor_octal_pos(idx);
  endfunction : m_slot

  int qs;
  int ms;
  assign qs = q_slot(int'(i_q_idx));
  assign ms = m_slot(int'(i_m_idx));

  always_comb begin
    next_st = st;
    next_st.err = i_q_we && qs < 0 || i_m_we && ms < 0;
    // Element inputs latched for the scan now running
    if (i_q_we && qs >= 0) begin
      next_st.qcur[qs] = i_q_in;
      next_st.term[qs] = st.first ? 1'b0 : i_q_in;
      next_st.qrb = st.qprev[qs];
    end
    if (i_m_we && ms >= 0) begin
      // Manual edits survive only when nothing drives the relay
      if (i_m_wired) next_st.mcur[ms] = i_m_in;
      else if (i_m_manual_we) next_st.mcur[ms] = i_m_manual_val;
      next_st.keep[ms] = i_m_keep;
      next_st.mout = st.mprev[ms];
    end
    // Units 8 and 9 never name a relay, so allocation steps over them
    if (i_m_alloc && 32'(st.alloc) < M_LIM) begin
      if (32'(st.alloc) % 10 == 7) next_st.alloc = st.alloc + REL_IDX_W'(3);
      else next_st.alloc = st.alloc + REL_IDX_W'(1);
    end
    if (i_scan) begin
      next_st.qprev = st.qcur;
      next_st.mprev = st.mcur;
      next_st.first = 1'b0;
    end
    if (i_start) begin
      next_st.first = 1'b1;
      next_st.term = '0;
      next_st.qcur = '0;
      next_st.qprev = '0;
      next_st.mcur = st.mprev & st.keep;
      next_st.mprev = st.mprev & st.keep;
      next_st.alloc = '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_terminals = st.term;
  assign o_q_readback = st.qrb;
  assign o_m_out = st.mout;
  assign o_m_next_idx = st.alloc;
  assign o_idx_err = st.err;

  sor_and4 #(.N(AND_INPUTS)) u_and (
    .i_in(i_and_in),
    .i_used(i_and_used),
    .o_out(o_and_out)
  );

  first_off_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_start |=> o_terminals == '0) else $error("terminals not off at start");
  term_follow_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_q_we && qs >= 0 && !st.first && !i_start) |=> o_terminals[$past(qs)] == $past(i_q_in))
    else $error("terminal not following input");
  q_delay_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_scan && !i_start |=> st.qprev == $past(st.qcur)) else $error("readback delay");
  m_delay_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_scan && !i_start |=> st.mprev == $past(st.mcur)) else $error("relay delay");
  keep_rel_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_start |=> st.mprev == ($past(st.mprev) & $past(st.keep))) else $error("keep lost");
  wired_win_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_m_we && ms >= 0 && i_m_wired && !i_start) |=> st.mcur[$past(ms)] == $past(i_m_in))
    else $error("manual not overridden");
  alloc_up_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_start |=> o_m_next_idx == '0) else $error("alloc not zero");
  bad_idx_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_q_we && qs < 0 |=> o_idx_err) else $error("bad index accepted");
  and_out_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (&(i_and_in | ~i_and_used)) == o_and_out) else $error("and wrong");

  // Element writes outside a start cycle, since the start clears the outputs and reloads relays from retained values
  sequence q_write_s;
    i_q_we && qs >= 0 && !i_start;
  endsequence
  sequence m_write_s;
    i_m_we && ms >= 0 && !i_start;
  endsequence

  first_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    st.first && i_q_we && qs >= 0 && !i_start |=> !o_terminals[$past(qs)])
    else $error("terminal on in first scan");
  q_readback_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    q_write_s |=> o_q_readback == $past(st.qprev[qs]))
    else $error("readback not previous scan");
  relay_out_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    m_write_s |=> o_m_out == $past(st.mprev[ms]))
    else $error("relay output not previous scan");
  manual_edit_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    m_write_s ##0 (!i_m_wired && i_m_manual_we) |=>
      st.mcur[$past(ms)] == $past(i_m_manual_val))
    else $error("manual edit lost");
  relay_idx_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_m_we && ms < 0 |=> o_idx_err) else $error("bad relay index accepted");
  alloc_step_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_m_alloc && !i_start && 32'(o_m_next_idx) < M_LIM |=>
      o_m_next_idx > $past(o_m_next_idx)) else $error("alloc not rising");
  alloc_octal_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    32'(o_m_next_idx) % 10 < 8) else $error("alloc names no relay");
  term_idle_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !i_q_we && !i_start |=> $stable(o_terminals)) else $error("terminal moved unasked");
  err_pulse_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !i_q_we && !i_m_we |=> !o_idx_err) else $error("error flag stuck");
endmodule : sor_scan

// ### tb/sor_load.sv
`timescale 1ns/1ps
module sor_load (
  input wire logic i_clk,
  input wire logic [71:0] i_terminals,
  output logic [71:0] o_state
);
  // Contactors pick up one cycle behind the terminals
  always_ff @(posedge i_clk) begin
    o_state <= i_terminals;
  end
endmodule : sor_load

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
  import sor_pkg::*;
  logic clk = 0, rst_n = 0, qwe = 0, qin = 0, mwe = 0, mval = 0;
  logic [2:0] pl = '0;
  logic [7:0] qidx = '0;
  logic [10:0] midx = '0, nidx;
  logic [3:0] ain = '0, aused = '0, mf = '0;
  logic [71:0] term, load, m = '0;
  logic qrb, mout, ierr, aout;
  int err_count = 0, total_checks = 0, cyc = 0, q, cn[5] = '{21, 22, 141, 142, 8};
  sor_scan dut_u (.i_clk(clk), .i_arst_n(rst_n), .i_scan(pl[0]), .i_start(pl[1]),
    .i_q_we(qwe), .i_q_idx(qidx), .i_q_in(qin), .i_m_we(mwe), .i_m_idx(midx),
    .i_m_in(mval), .i_m_wired(mf[0]), .i_m_manual_we(mf[1]), .i_m_manual_val(mf[2]),
    .i_m_keep(mf[3]), .i_m_alloc(pl[2]), .i_and_in(ain), .i_and_used(aused),
    .o_terminals(term), .o_q_readback(qrb), .o_m_out(mout), .o_m_next_idx(nidx),
    .o_idx_err(ierr), .o_and_out(aout));
  sor_load load_u (.i_clk(clk), .i_terminals(term), .o_state(load));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic chk(string n, logic [71:0] e, logic [71:0] s);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, s);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // Octal units within the base range or a bank
  function automatic int slot(int i);
    int k;
    k = i / 40;
    i = i - 40 * k;
    return 18 * k + (i / 10) * 8 + i % 10;
  endfunction : slot
  // Only a wired input that is off pulls the result low
  function automatic logic and_exp(logic [3:0] a, logic [3:0] u);
    and_exp = 1'b1;
    for (int j = 0; j < 4; j++) begin
      if (u[j] && !a[j]) and_exp = 1'b0;
    end
  endfunction : and_exp
  task automatic pulse(int b);
    @(posedge clk);
    pl[b] <= 1;
    @(posedge clk);
    pl <= '0;
    @(negedge clk);
  endtask : pulse
  // Relay flags f: keep, manual value, manual write, wired
  task automatic wr(bit r, int i, logic v, logic [3:0] f = 4'h1);
    @(posedge clk);
    if (r) mwe <= 1;
    else qwe <= 1;
    qidx <= i[7:0];
    midx <= i[10:0];
    qin <= v;
    mval <= v;
    mf <= f;
    @(posedge clk);
    qwe <= 0;
    mwe <= 0;
    mf <= 4'h0;
    @(negedge clk);
  endtask : wr
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      final_report();
    end
  end
  initial begin
    void'($urandom(55933));
    repeat (4) @(posedge clk);
    rst_n <= 1;
    @(negedge clk);
    chk("next_idx", 0, nidx);
    pulse(1);
    wr(0, 5, 1);
    chk("first_scan", 72'h0, term);
    pulse(0);
    for (int i = 0; i < 45; i++) begin
      q = (i < 5) ? cn[i] : int'($urandom % 151);
      wr(0, q, 1'($urandom % 2));
      if (q % 10 < 8 && q % 40 < 22 && q < 142) m[slot(q)] = qin;
      chk("idx_err", !(q % 10 < 8 && q % 40 < 22 && q < 142), ierr);
      chk("terminals", m, term);
    end
    @(negedge clk);
    chk("load", m, load);
    $display("test outputs end");
    wr(0, 41, 1);
    pulse(0);
    wr(0, 41, 0);
    chk("q_readback", 1, qrb);
    pulse(0);
    wr(0, 41, 0);
    chk("q_readback", 0, qrb);
    wr(1, 1277, 1);
    chk("m_idx_err", 0, ierr);
    pulse(0);
    wr(1, 1277, 0);
    chk("m_out", 1, mout);
    pulse(0);
    wr(1, 1277, 0);
    chk("m_out", 0, mout);
    wr(1, 1280, 1);
    chk("m_idx_err", 1, ierr);
    wr(1, 10, 1, 4'h3);
    pulse(0);
    wr(1, 10, 0, 4'h0);
    chk("m_wired", 1, mout);
    wr(1, 11, 0, 4'h6);
    pulse(0);
    wr(1, 11, 0, 4'h0);
    chk("m_manual", 1, mout);
    wr(1, 20, 1, 4'h9);
    wr(1, 21, 1);
    pulse(0);
    pulse(1);
    wr(1, 20, 0, 4'h8);
    chk("m_keep", 1, mout);
    wr(1, 21, 0, 4'h0);
    chk("m_clear", 0, mout);
    pulse(2);
    pulse(2);
    chk("next_idx", 2, nidx);
    repeat (6) pulse(2);
    chk("next_idx", 10, nidx);
    $display("test readback relay end");
    for (int i = 0; i < 256; i++) begin
      @(posedge clk);
      ain <= i[3:0];
      aused <= i[7:4];
      @(negedge clk);
      chk("and_out", and_exp(i[3:0], i[7:4]), aout);
    end
    $display("test and end");
    final_report();
  end
endmodule : tb
